//--- dv/rmpc_link_model.sv
// Purpose: far-side source of received bit clock and data
// Assumes: 320 ns bit period, edges fixed 7 ns after a falling clk edge
// Notes: clock stands still outside frames, data keeps changing there
`timescale 1ns/1ns
`default_nettype none
module rmpc_link_model (
	input wire logic en,
	output var logic bclk,
	output var logic data
);
	logic [7:0] pat;
	initial begin
		bclk = 1'b0;
		data = 1'b0;
		pat = 8'hb4;
		#7;
		forever begin
			#160;
			if (en) begin
				bclk = ~bclk;
				if (!bclk) begin
					data = pat[0];
					pat = {pat[0], pat[7:1]};
				end
			end else begin
				// idle data is not a held value
				data = ~data;
			end
		end
	end
endmodule // rmpc_link_model
`default_nettype wire

//--- dv/rmpc_monitor.sv
// Purpose: port-level checks on rmpc_top
// Assumes: one clock domain, synchronous reset
// Notes: bound from the testbench top
`timescale 1ns/1ns
`default_nettype none
module rmpc_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic       serial_data_pin_oe,
	input wire logic       direction_tx,
	input wire logic       chip_sleep,
	input wire logic       wakeup_start,
	input wire logic       calibrate_start,
	input wire logic       sequence_done,
	input wire logic       soft_reset_active,
	input wire logic       amp_enable_pin,
	input wire logic       low_noise_enable_pin,
	input wire logic       oscillator_bypass,
	input wire logic       test_block_sleep,
	input wire logic [2:0] test_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_asleep; $rose(chip_sleep); endsequence
	// two cycles so the pin side has had one edge to take its defaults
	sequence s_srst; soft_reset_active [*2]; endsequence
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write response held after handshake");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("read response held after handshake");
	property p_awref; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_awref: assert property (p_awref) else $error("write address taken during response");
	property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arref: assert property (p_arref) else $error("read address taken during response");
	property p_oe; serial_data_pin_oe |-> !direction_tx; endproperty
	a_oe: assert property (p_oe) else $error("data pin driven in transmit");
	property p_sleep; s_asleep |-> !direction_tx; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep outside receive");
	property p_wake; wakeup_start |-> $past(chip_sleep); endproperty
	a_wake: assert property (p_wake) else $error("wake pulse while awake");
	property p_cal; calibrate_start |-> $past(sequence_done); endproperty
	a_cal: assert property (p_cal) else $error("calibration without sequence end");
	property p_srst;
		s_srst |-> !amp_enable_pin && !low_noise_enable_pin && !oscillator_bypass && test_block_sleep
			&& test_mode == 3'h1;
	endproperty
	a_srst: assert property (p_srst) else $error("pin side not defaulted");
endmodule // rmpc_monitor
`default_nettype wire

//--- dv/rmpc_test.sv
// Purpose: self-checking bench for rmpc_top
// Assumes: AXI4-Lite master tasks, 25 MHz clk
// Notes: control register is written before any pin decode is checked
`timescale 1ns/1ns
`default_nettype none
module rmpc_test;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, serial_data_pin_i = 1'b1, select_pin_n = 1'b1;
	logic        sync_mode = 1'b0, synth_locked = 1'b0, carrier_sense = 1'b0, sequence_done = 1'b0, link_en = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rd;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  resp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_data, rx_bit_clock;
	wire         serial_data_pin_o, serial_data_pin_oe, lock_pin, bit_clock_pin, tx_data, amp_enable_pin;
	wire         low_noise_enable_pin, direction_tx, synth_word_b, synth_sleep, oscillator_core_sleep;
	wire         bias_generator_sleep, oscillator_bypass, rx_chain_sleep, amp_sleep, chip_sleep, wakeup_start;
	wire         calibrate_start, soft_reset_active, test_block_sleep;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [2:0]   test_mode;
	int          miscompares = 0, check_count = 0, cal_seen = 0, i, n;
	logic [23:0] rows [6] = '{24'h010000, 24'h010318, 24'h018f2a, 24'h0f0c17, 24'hc10fd0, 24'h910f80};
	int          cal_exp [4] = '{0, 16, 1, 1};
	rmpc_top dut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_data_pin_i,
		.serial_data_pin_o, .serial_data_pin_oe, .lock_pin, .bit_clock_pin, .select_pin_n, .rx_data, .tx_data,
		.rx_bit_clock, .sync_mode, .synth_locked, .carrier_sense, .amp_enable_pin, .low_noise_enable_pin,
		.direction_tx, .synth_word_b, .synth_sleep, .oscillator_core_sleep, .bias_generator_sleep,
		.oscillator_bypass, .rx_chain_sleep, .amp_sleep, .chip_sleep, .wakeup_start, .calibrate_start,
		.soft_reset_active, .sequence_done, .test_block_sleep, .test_mode);
	rmpc_link_model u_link (.en(link_en), .bclk(rx_bit_clock), .data(rx_data));
	always #20 clk = ~clk;
	always @(posedge clk) if (calibrate_start === 1'b1) cal_seen <= cal_seen + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		s_axi_awaddr <= {22'h0, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [7:0] idx);
		s_axi_araddr <= {22'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_wake;
		n = 0;
		while (wakeup_start !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic zeros;
		n = 0;
		repeat (64) begin
			@(posedge clk);
			if (bit_clock_pin === 1'b0) n++;
		end
	endtask
	task automatic stop_test;
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdr(8'h01); chk(rd, 32'h0);
		rdr(8'h02); chk(rd, 32'h80);
		rdr(8'h05); chk({30'h0, resp, rd[29:0]}, 32'h80000000);
		wr(8'h04, 8'hff); chk({30'h0, resp}, 32'h2);
		for (i = 0; i < 6; i++) begin
			wr(8'h00, rows[i][23:16]);
			wr(8'h01, rows[i][15:8]);
			rdr(8'h01); chk(rd, {24'h0, rows[i][15:8]});
			chk({24'h0, direction_tx, synth_word_b, oscillator_bypass, amp_enable_pin, low_noise_enable_pin,
				synth_sleep, oscillator_core_sleep, bias_generator_sleep}, {24'h0, rows[i][7:0]});
		end
		wr(8'h01, 8'h8f);
		wr(8'h00, 8'h00);
		chk({31'h0, soft_reset_active}, 32'h1);
		rdr(8'h01); chk(rd, 32'h0);
		wr(8'h00, 8'hc1);
		rdr(8'h00); chk(rd, 32'hc1);
		for (i = 0; i < 4; i++) begin
			wr(8'h03, i[7:0] & 8'h03);
			wr(8'h01, 8'h04 + i[7:0]);
			chk({28'h0, test_block_sleep, test_mode}, i == 0 ? 32'h9 : 32'h4 + i);
		end
		wr(8'h03, 8'h00);
		wr(8'h00, 8'h01);
		wr(8'h01, 8'h00); chk({31'h0, serial_data_pin_oe}, 32'h1);
		wr(8'h01, 8'h40); chk({31'h0, serial_data_pin_oe}, 32'h0);
		wr(8'h00, 8'h21);
		wr(8'h00, 8'h23); chk({31'h0, chip_sleep}, 32'h0);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h31);
		wr(8'h00, 8'h33); chk({31'h0, chip_sleep}, 32'h1);
		select_pin_n <= 1'b0;
		wait_wake; chk({31'h0, wakeup_start}, 32'h1);
		select_pin_n <= 1'b1;
		wr(8'h02, 8'h00);
		wr(8'h01, 8'h40);
		wr(8'h00, 8'h31);
		wr(8'h00, 8'h33);
		select_pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk({31'h0, chip_sleep}, 32'h1);
		serial_data_pin_i <= 1'b0;
		wait_wake; chk({31'h0, wakeup_start}, 32'h1);
		chk({31'h0, tx_data}, 32'h0);
		serial_data_pin_i <= 1'b1;
		select_pin_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wr(8'h00, 8'h31 | (i[7:0] << 2));
			n = cal_seen;
			repeat (i == 3 ? 256 : 16) begin
				sequence_done <= 1'b1;
				@(posedge clk);
				sequence_done <= 1'b0;
				@(posedge clk);
			end
			repeat (4) @(posedge clk);
			chk(cal_seen - n, cal_exp[i]);
		end
		sync_mode <= 1'b1;
		link_en <= 1'b1;
		wr(8'h00, 8'h01);
		wr(8'h01, 8'h10);
		zeros; chk(n, 32'h0);
		carrier_sense <= 1'b1;
		zeros; chk({31'h0, n > 0}, 32'h1);
		wr(8'h00, 8'h11);
		wr(8'h01, 8'h20);
		zeros; chk(n, 32'h0);
		synth_locked <= 1'b1;
		zeros; chk({31'h0, n > 0}, 32'h1);
		chk({31'h0, lock_pin}, 32'h1);
		link_en <= 1'b0;
		stop_test();
	end
	initial begin
		#3000000;
		miscompares++;
		stop_test();
	end
endmodule // rmpc_test
bind rmpc_top rmpc_monitor u_mon (.clk, .rst, .s_axi_awready, .s_axi_arready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_rvalid, .s_axi_rready, .serial_data_pin_oe, .direction_tx, .chip_sleep, .wakeup_start,
	.calibrate_start, .sequence_done, .soft_reset_active, .amp_enable_pin, .low_noise_enable_pin,
	.oscillator_bypass, .test_block_sleep, .test_mode);
`default_nettype wire

//--- hdl/rmpc_map.vh
// Purpose: constants for the radio mode and pin control register bank
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef RMPC_MAP_VH
`define RMPC_MAP_VH
`define RMPC_IDX_CTRL        8'h00
`define RMPC_IDX_PINCFG      8'h01
`define RMPC_IDX_SEQCFG      8'h02
`define RMPC_IDX_TESTCFG     8'h03
`define RMPC_IDX_STATUS      8'h04
`define RMPC_PINCFG_RST      8'h00
`define RMPC_SEQCFG_RST      8'h80
`define RMPC_TESTCFG_RST     8'h00
`define RMPC_B_DIR           7
`define RMPC_B_FSEL          6
`define RMPC_B_PDS_HI        5
`define RMPC_B_PDS_LO        4
`define RMPC_B_CAL_HI        3
`define RMPC_B_CAL_LO        2
`define RMPC_B_SLEEP         1
`define RMPC_B_SRST_N        0
`define RMPC_B_BYPASS        7
`define RMPC_B_SPLIT         6
`define RMPC_B_GLOCK         5
`define RMPC_B_GCS           4
`define RMPC_B_EXTPA         3
`define RMPC_B_EXTLNA        2
`define RMPC_B_PAPOL         1
`define RMPC_B_LNAPOL        0
`define RMPC_B_PSELTRIG      7
`define RMPC_B_TFEN          1
`define RMPC_B_TAEN          0
`define RMPC_PDS_SPLIT       2'b00
`define RMPC_PDS_BOTH        2'b01
`define RMPC_PDS_SEQ         2'b11
`define RMPC_CAL_NEVER       2'b00
`define RMPC_CAL_EVERY       2'b01
`define RMPC_CAL_16          2'b10
`define RMPC_CAL_256         2'b11
`define RMPC_TEST_SLEEP_DEF  1'b1
`define RMPC_TEST_MODE_DEF   3'h1
`define RMPC_RESP_OKAY       2'b00
`define RMPC_RESP_SLVERR     2'b10
`endif

//--- hdl/rmpc_sync2.v
// Purpose: two-flop synchroniser for an input from outside the clock domain
// Assumes: second stage is the only reader of the first
// Notes: clock enable freezes both stages
`timescale 1ns/1ns
`default_nettype none
module rmpc_sync2 (
	input  wire clk,
	input  wire rst,
	input  wire ce,
	input  wire d,
	output wire q
);
	reg	meta_ff;
	reg	sync_ff;

	always @(posedge clk) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else if (ce) begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule // rmpc_sync2
`default_nettype wire

//--- hdl/rmpc_top.v
// Purpose: radio mode and pin control register bank behind an AXI4-Lite slave
// Assumes: 25 MHz clk, synchronous active-high rst, ce freezes all state
// Notes: control register is never reset by rst; every other register is defaulted
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rmpc_map.vh"
module rmpc_top (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        serial_data_pin_i,
	output wire        serial_data_pin_o,
	output wire        serial_data_pin_oe,
	output wire        lock_pin,
	output wire        bit_clock_pin,
	input  wire        select_pin_n,
	input  wire        rx_data,
	output wire        tx_data,
	input  wire        rx_bit_clock,
	input  wire        sync_mode,
	input  wire        synth_locked,
	input  wire        carrier_sense,
	output wire        amp_enable_pin,
	output wire        low_noise_enable_pin,
	output wire        direction_tx,
	output wire        synth_word_b,
	output wire        synth_sleep,
	output wire        oscillator_core_sleep,
	output wire        bias_generator_sleep,
	output wire        oscillator_bypass,
	output wire        rx_chain_sleep,
	output wire        amp_sleep,
	output wire        chip_sleep,
	output wire        wakeup_start,
	output wire        calibrate_start,
	output wire        soft_reset_active,
	input  wire        sequence_done,
	output wire        test_block_sleep,
	output wire [2:0]  test_mode
);
	reg	[7:0]	ctrl_ff;
	reg	[7:0]	pincfg_ff;
	reg	[7:0]	seqcfg_ff;
	reg	[7:0]	testcfg_ff;
	reg	[7:0]	seqcnt_ff;
	reg		sleep_ff;
	reg		wake_ff;
	reg		cal_ff;
	reg		dio_d_ff;
	reg		psel_d_ff;
	reg		aw_ff;
	reg		w_ff;
	reg	[7:0]	awidx_ff;
	reg	[7:0]	wdat_ff;
	reg		wstb_ff;
	reg		bvalid_ff;
	reg	[1:0]	bresp_ff;
	reg		rvalid_ff;
	reg	[31:0]	rdata_ff;
	reg	[1:0]	rresp_ff;
	wire		dio_s;
	wire		psel_s;
	wire		rxd_s;
	wire		rxclk_s;
	wire		lock_s;
	wire		cs_s;

	// every pin-side input except sync_mode and sequence_done crosses through two flops first
	rmpc_sync2 u_sync_dio (.clk(clk), .rst(rst), .ce(ce), .d(serial_data_pin_i), .q(dio_s));
	rmpc_sync2 u_sync_psel (.clk(clk), .rst(rst), .ce(ce), .d(select_pin_n), .q(psel_s));
	rmpc_sync2 u_sync_rxd (.clk(clk), .rst(rst), .ce(ce), .d(rx_data), .q(rxd_s));
	rmpc_sync2 u_sync_rxclk (.clk(clk), .rst(rst), .ce(ce), .d(rx_bit_clock), .q(rxclk_s));
	rmpc_sync2 u_sync_lock (.clk(clk), .rst(rst), .ce(ce), .d(synth_locked), .q(lock_s));
	rmpc_sync2 u_sync_cs (.clk(clk), .rst(rst), .ce(ce), .d(carrier_sense), .q(cs_s));

	function is_mapped;
		input [7:0] idx;
		begin
			is_mapped = (idx <= `RMPC_IDX_STATUS);
		end
	endfunction

	function is_writable;
		input [7:0] idx;
		begin
			is_writable = (idx < `RMPC_IDX_STATUS);
		end
	endfunction

	wire	[1:0]	pds     = ctrl_ff[`RMPC_B_PDS_HI:`RMPC_B_PDS_LO];
	wire		dir_tx  = ctrl_ff[`RMPC_B_DIR];
	wire		srst    = ~ctrl_ff[`RMPC_B_SRST_N];
	wire		seq_en  = (pds == `RMPC_PDS_SEQ);
	wire		seq_md  = seq_en & ~dir_tx;
	wire	[1:0]	cadence = ctrl_ff[`RMPC_B_CAL_HI:`RMPC_B_CAL_LO];
	wire		split   = pincfg_ff[`RMPC_B_SPLIT];
	wire		psel_tr = seqcfg_ff[`RMPC_B_PSELTRIG];
	wire		test_en = testcfg_ff[`RMPC_B_TFEN] | testcfg_ff[`RMPC_B_TAEN];

	// AXI write: address and data are accepted independently, then one response
	wire	do_write = aw_ff & w_ff & ~bvalid_ff;
	assign s_axi_awready = ~aw_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_ff & ~bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	wire	wr_ctrl = do_write & wstb_ff & (awidx_ff == `RMPC_IDX_CTRL);
	wire	wr_pin  = do_write & wstb_ff & (awidx_ff == `RMPC_IDX_PINCFG);
	wire	wr_seq  = do_write & wstb_ff & (awidx_ff == `RMPC_IDX_SEQCFG);
	wire	wr_tst  = do_write & wstb_ff & (awidx_ff == `RMPC_IDX_TESTCFG);

	always @(posedge clk) begin
		if (rst) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awidx_ff  <= 8'h00;
			wdat_ff   <= 8'h00;
			wstb_ff   <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= `RMPC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_ff <= 1'b1;
				awidx_ff <= (s_axi_awaddr[31:10] == 22'h000000) ? s_axi_awaddr[9:2] : 8'hff;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_ff    <= 1'b1;
				wdat_ff <= s_axi_wdata[7:0];
				wstb_ff <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_ff     <= 1'b0;
				w_ff      <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= is_writable(awidx_ff) ? `RMPC_RESP_OKAY : `RMPC_RESP_SLVERR;
			end else if (bvalid_ff & s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// control register is outside the reset domain: it holds what the host wrote
	always @(posedge clk) begin
		if (ce & wr_ctrl)
			ctrl_ff <= wdat_ff;
	end

	// configuration registers return to defaults on rst or while soft reset is low
	always @(posedge clk) begin
		if (rst) begin
			pincfg_ff  <= `RMPC_PINCFG_RST;
			seqcfg_ff  <= `RMPC_SEQCFG_RST;
			testcfg_ff <= `RMPC_TESTCFG_RST;
		end else if (ce) begin
			if (srst) begin
				pincfg_ff  <= `RMPC_PINCFG_RST;
				seqcfg_ff  <= `RMPC_SEQCFG_RST;
				testcfg_ff <= `RMPC_TESTCFG_RST;
			end else begin
				if (wr_pin)
					pincfg_ff <= wdat_ff;
				if (wr_seq)
					seqcfg_ff <= wdat_ff;
				if (wr_tst)
					testcfg_ff <= wdat_ff;
			end
		end
	end

	// AXI read
	reg	[7:0]	rd_mux;
	always @* begin
		case (s_axi_araddr[9:2])
		`RMPC_IDX_CTRL:    rd_mux = ctrl_ff;
		`RMPC_IDX_PINCFG:  rd_mux = pincfg_ff;
		`RMPC_IDX_SEQCFG:  rd_mux = seqcfg_ff;
		`RMPC_IDX_TESTCFG: rd_mux = testcfg_ff;
		`RMPC_IDX_STATUS:  rd_mux = {4'h0, cal_ff, sleep_ff, lock_s, cs_s};
		default:           rd_mux = 8'h00;
		endcase
	end

	wire	rd_ok = is_mapped(s_axi_araddr[9:2]) & (s_axi_araddr[31:10] == 22'h000000);

	always @(posedge clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `RMPC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid & s_axi_arready) begin
				rvalid_ff <= 1'b1;
				rdata_ff  <= rd_ok ? {24'h000000, rd_mux} : 32'h00000000;
				rresp_ff  <= rd_ok ? `RMPC_RESP_OKAY : `RMPC_RESP_SLVERR;
			end else if (rvalid_ff & s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// sequencing: wake-up triggers, sleep request and calibration cadence
	wire	dio_fall  = dio_d_ff & ~dio_s;
	wire	psel_fall = psel_d_ff & ~psel_s;
	wire	trig_dio  = dio_fall & split & ~psel_tr & seq_en;
	wire	trig_psel = psel_fall & psel_tr & seq_en;
	wire	sleep_req = seq_md & wr_ctrl & ~ctrl_ff[`RMPC_B_SLEEP] & wdat_ff[`RMPC_B_SLEEP];
	reg	cal_due;
	always @* begin
		case (cadence)
		`RMPC_CAL_NEVER: cal_due = 1'b0;
		`RMPC_CAL_EVERY: cal_due = 1'b1;
		`RMPC_CAL_16:    cal_due = (seqcnt_ff[3:0] == 4'hf);
		`RMPC_CAL_256:   cal_due = (seqcnt_ff == 8'hff);
		default:         cal_due = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			// match the synchroniser reset level so release gives a rise, never a false fall
			dio_d_ff  <= 1'b0;
			psel_d_ff <= 1'b0;
			sleep_ff  <= 1'b0;
			wake_ff   <= 1'b0;
			cal_ff    <= 1'b0;
			seqcnt_ff <= 8'h00;
		end else if (ce) begin
			dio_d_ff  <= dio_s;
			psel_d_ff <= psel_s;
			wake_ff   <= sleep_ff & (trig_dio | trig_psel);
			cal_ff    <= seq_md & sequence_done & cal_due;
			if (srst) begin
				seqcnt_ff <= 8'h00;
				sleep_ff  <= 1'b0;
			end else begin
				if (seq_md & sequence_done)
					seqcnt_ff <= seqcnt_ff + 8'h01;
				if (sleep_req)
					sleep_ff <= 1'b1;
				else if (~seq_md | trig_dio | trig_psel)
					sleep_ff <= 1'b0;
			end
		end
	end

	// power control outputs
	wire	both_off = (pds == `RMPC_PDS_BOTH);
	assign direction_tx          = dir_tx;
	assign synth_word_b          = ctrl_ff[`RMPC_B_FSEL];
	assign synth_sleep           = ~seq_md & ctrl_ff[`RMPC_B_CAL_HI];
	assign oscillator_core_sleep = ~seq_md & ctrl_ff[`RMPC_B_CAL_LO] | pincfg_ff[`RMPC_B_BYPASS];
	assign bias_generator_sleep  = ~seq_md & ctrl_ff[`RMPC_B_SLEEP];
	assign oscillator_bypass     = pincfg_ff[`RMPC_B_BYPASS];
	assign rx_chain_sleep        = both_off | (pds == `RMPC_PDS_SPLIT & dir_tx) | sleep_ff;
	assign amp_sleep             = both_off | (pds == `RMPC_PDS_SPLIT & ~dir_tx) | seq_md;
	assign chip_sleep            = sleep_ff;
	assign wakeup_start          = wake_ff;
	assign calibrate_start       = cal_ff;
	assign soft_reset_active     = srst;

	// data pin routing
	assign serial_data_pin_oe = ~split & ~dir_tx;
	assign serial_data_pin_o  = rxd_s;
	assign tx_data            = dio_s;
	assign lock_pin           = (split & sync_mode) ? rxd_s : lock_s;

	// bit clock gating; held high is the idle level the host can ignore
	wire	gate_lock = sync_mode & pincfg_ff[`RMPC_B_GLOCK] & both_off & ~lock_s;
	wire	gate_cs   = sync_mode & pincfg_ff[`RMPC_B_GCS] & ~cs_s;
	assign bit_clock_pin = (split & ~sync_mode) ? rxd_s : (rxclk_s | gate_lock | gate_cs);

	// external amplifier pins; test mode borrows the low four bits
	wire	amp_on = ~amp_sleep;
	wire	lna_on = ~rx_chain_sleep;
	assign amp_enable_pin = (pincfg_ff[`RMPC_B_EXTPA] & ~amp_on) ? ~pincfg_ff[`RMPC_B_PAPOL]
		: pincfg_ff[`RMPC_B_PAPOL];
	assign low_noise_enable_pin = (pincfg_ff[`RMPC_B_EXTLNA] & ~lna_on) ? ~pincfg_ff[`RMPC_B_LNAPOL]
		: pincfg_ff[`RMPC_B_LNAPOL];
	assign test_block_sleep = test_en ? pincfg_ff[3] : `RMPC_TEST_SLEEP_DEF;
	assign test_mode        = test_en ? pincfg_ff[2:0] : `RMPC_TEST_MODE_DEF;
endmodule // rmpc_top
`default_nettype wire
